// [host_bus_model.sv]
`timescale 1ns/100ps
`include "radio_regs_params.svh"
module host_bus_model
(
    // clock
    input wire logic i_sys_clk,
    // avalon-mm master
    input wire logic i_waitrequest,
    output logic [`AV_ADDR_W-1:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [`AV_BE_W-1:0] o_byteenable,
    output logic [`AV_DATA_W-1:0] o_writedata
);
    import radio_regs_pkg::*;
    logic [`AV_DATA_W-1:0] exp_q[$];
    initial
    begin
        o_address = 6'h3f;
        o_read = 1'b0;
        o_write = 1'b0;
        o_byteenable = 4'h0;
        o_writedata = 32'h0;
    end
    // called at a rising edge; released lines show inverted values
    task automatic xfer(input logic w, input logic [5:0] a,
        input logic [31:0] d, input logic [3:0] be);
        o_address <= a;
        o_writedata <= d;
        o_byteenable <= be;
        o_write <= w;
        o_read <= !w;
        @(posedge i_sys_clk);
        while (i_waitrequest !== 1'b0)
            @(posedge i_sys_clk);
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_address <= ~a;
        o_writedata <= ~d;
        o_byteenable <= ~be;
        @(posedge i_sys_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be);
        xfer(1'b1, a, d, be);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, ~e, 4'hf);
    endtask
endmodule

// [irq_events.sv]
`timescale 1ns/100ps
`include "radio_regs_params.svh"
module irq_events
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_clk_en,
    input wire logic i_rst_n,
    // events, one-cycle pulses
    input wire logic [`EVT_COUNT-1:0] i_event,
    // software access
    input wire logic [`EVT_COUNT-1:0] i_clear,
    input wire logic i_mask_wr,
    input wire logic [`EVT_COUNT-1:0] i_mask_data,
    // state
    output logic [`EVT_COUNT-1:0] o_status,
    output logic [`EVT_COUNT-1:0] o_mask,
    output logic o_irq
);

    logic [`EVT_COUNT-1:0] status_ff;
    logic [`EVT_COUNT-1:0] mask_ff;
    logic irq_ff;
    logic [`EVT_COUNT-1:0] nxt_status;
    logic [`EVT_COUNT-1:0] nxt_mask;
    logic nxt_irq;

    // an event in the cycle of its clear still lands
    genvar g;
    generate
        for (g = 0; g < `EVT_COUNT; g++)
        begin : g_bit
            always_comb
            begin
                nxt_status[g] = i_event[g] | (status_ff[g] & ~i_clear[g]);
            end
        end
    endgenerate

    always_comb
    begin
        nxt_mask = i_mask_wr ? i_mask_data : mask_ff;
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            status_ff <= '0;
            mask_ff <= '0;
            irq_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
        end
    end

    assign o_status = status_ff;
    assign o_mask = mask_ff;
    assign o_irq = irq_ff;

endmodule

// [radio_regs_chk.sv]
`timescale 1ns/100ps
`include "radio_regs_params.svh"
module radio_regs_chk
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // bus
    input wire logic [`AV_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [`AV_BE_W-1:0] i_avs_byteenable,
    input wire logic [`AV_DATA_W-1:0] i_avs_writedata,
    input wire logic [`AV_DATA_W-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // core state and events
    input wire radio_regs_pkg::code2_type i_clk_source,
    input wire radio_regs_pkg::code2_type i_wake_progress,
    input wire radio_regs_pkg::code2_type i_chan_a,
    input wire radio_regs_pkg::code2_type i_chan_b,
    input wire logic i_evt_wake_fail,
    // settings and interrupt
    input wire logic [`REG_W-1:0] o_synth_int,
    input wire logic [3*`REG_W-1:0] o_synth_frac,
    input wire logic [2*`REG_W-1:0] o_fsk_dev,
    input wire logic [2*`REG_W-1:0] o_chan_offset,
    input wire logic o_irq
);
    import radio_regs_pkg::*;
    logic rd_end;
    logic wr_end;
    logic irq_wr;
    assign rd_end = i_avs_read && !o_avs_waitrequest;
    assign wr_end = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    // the interrupt may only drop after software touched status or mask
    assign irq_wr = i_avs_write && !o_avs_waitrequest &&
        (i_avs_address == `IDX_IRQ_STATUS || i_avs_address == `IDX_IRQ_MASK);

    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    sequence status_read_taken;
        i_avs_read && o_avs_waitrequest && i_avs_address == `IDX_EVT_CLK_WAKE;
    endsequence
    sequence wake_fail_then_read;
        i_evt_wake_fail ##1 status_read_taken;
    endsequence

    read_upper_zero_a: assert property (rd_end |->
        o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    clock_wake_bits_a: assert property (rd_end &&
        i_avs_address == 6'h02 |-> o_avs_readdata[5:0] ==
        {2'b00, $past(i_clk_source), $past(i_wake_progress)})
        else $error("clock or wake field wrong");
    channel_bits_a: assert property (rd_end &&
        i_avs_address == 6'h03 |-> o_avs_readdata[7:0] ==
        {4'h0, $past(i_chan_a), $past(i_chan_b)})
        else $error("channel status wrong");
    wake_fail_cause_a: assert property (wake_fail_then_read |=>
        o_avs_readdata[7:6] == `CAUSE_WAKE_FAIL)
        else $error("wake failure cause not shown");
    divider_update_a: assert property (wr_end &&
        i_avs_address == 6'h04 |=>
        o_synth_int == $past(i_avs_writedata[7:0]))
        else $error("divider output not updated");
    fraction_hold_a: assert property (
        !(wr_end && i_avs_address == 6'h07) |=> $stable(o_synth_frac))
        else $error("fraction changed without low byte write");
    fraction_low_a: assert property (wr_end &&
        i_avs_address == 6'h07 |=>
        o_synth_frac[7:0] == $past(i_avs_writedata[7:0]))
        else $error("fraction low byte wrong");
    deviation_hold_a: assert property (
        !(wr_end && i_avs_address == 6'h09) |=> $stable(o_fsk_dev))
        else $error("deviation changed without low byte write");
    offset_hold_a: assert property (
        !(wr_end && i_avs_address == 6'h0b) |=> $stable(o_chan_offset))
        else $error("offset changed without low byte write");
    single_ack_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    irq_drop_a: assert property ($fell(o_irq) |->
        $past(irq_wr) || $past(irq_wr, 2))
        else $error("interrupt dropped without software access");
endmodule
bind radio_status_and_synth_regs radio_regs_chk u_radio_regs_chk (.*);

// [radio_regs_params.svh]
`ifndef RADIO_REGS_PARAMS_SVH
`define RADIO_REGS_PARAMS_SVH

// ****************************************************************
// bus geometry
// ****************************************************************
`define AV_ADDR_W 6
`define AV_DATA_W 32
`define AV_BE_W 4
`define REG_W 8

// ****************************************************************
// register indices, word addresses on the bus
// ****************************************************************
`define IDX_EVT_CLK_WAKE 6'h02
`define IDX_CUR_CHANNEL 6'h03
`define IDX_CFG_BASE 6'h04
`define IDX_INT_DIV 6'h04
`define IDX_FRAC_HIGH 6'h05
`define IDX_FRAC_MID 6'h06
`define IDX_FRAC_LOW 6'h07
`define IDX_DEV_HIGH 6'h08
`define IDX_DEV_LOW 6'h09
`define IDX_OFS_HIGH 6'h0a
`define IDX_OFS_LOW 6'h0b
`define IDX_IRQ_STATUS 6'h10
`define IDX_IRQ_MASK 6'h11

// ****************************************************************
// configuration byte slots, counted from the first synth register
// ****************************************************************
`define CFG_COUNT 8
`define SLOT_INT_DIV 0
`define SLOT_FRAC_HIGH 1
`define SLOT_FRAC_MID 2
`define SLOT_FRAC_LOW 3
`define SLOT_DEV_HIGH 4
`define SLOT_DEV_LOW 5
`define SLOT_OFS_HIGH 6
`define SLOT_OFS_LOW 7
`define CFG_RESET 8'h00

// ****************************************************************
// event bits of the sticky status and mask registers
// ****************************************************************
`define EVT_COUNT 3
`define EVT_RX_B 0
`define EVT_RX_A 1
`define EVT_WAKE_FAIL 2

// ****************************************************************
// interrupt cause codes
// ****************************************************************
`define CAUSE_NONE 2'h0
`define CAUSE_RX_B 2'h1
`define CAUSE_RX_A 2'h2
`define CAUSE_WAKE_FAIL 2'h3

`endif

// [radio_regs_pkg.sv]
package radio_regs_pkg;

    // ************************************************************
    // shared types
    // ************************************************************
    typedef logic [1:0] code2_type;

    typedef enum logic [0:0]
    {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_type;

endpackage

// [radio_status_and_synth_regs.sv]
// What this block does
// - Bits 7:6 of the event/clock/wake status give the pending cause: 11 wake failure, 10 profile A data, 01 profile B data, 00 none.
// - Bits 3:2 of that status show the digital clock source: 10 slow oscillator, 01 fast-wake oscillator, 00 crystal, 11 unused.
// - Bits 1:0 of that status show fast-wake progress: 11 done and failed, 10 done and good, 01 not started, 00 never calibrated.
// - Bits 3:2 of the channel status give profile A's channel: 10 base plus spacing, 01 base minus spacing, 00 base, 11 unused.
// - Bits 1:0 of the channel status give profile B's channel with the same coding.
// - The synthesizer takes its integer division ratio from the eight-bit integer divider register.
// - The 24-bit fraction is built from high byte 23:16, middle byte 15:8 and low byte 7:0.
// - The 16-bit FSK peak deviation is built from a high byte 15:8 and a low byte 7:0.
// - The 16-bit channel offset is built from two byte registers in the same way.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`include "radio_regs_params.svh"
module radio_status_and_synth_regs
(
    // clock, enable and reset
    input wire logic i_sys_clk,
    input wire logic i_clk_en,
    input wire logic i_arst_n,
    // avalon-mm slave
    input wire logic [`AV_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [`AV_BE_W-1:0] i_avs_byteenable,
    input wire logic [`AV_DATA_W-1:0] i_avs_writedata,
    output logic [`AV_DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // radio core state
    input wire radio_regs_pkg::code2_type i_clk_source,
    input wire radio_regs_pkg::code2_type i_wake_progress,
    input wire radio_regs_pkg::code2_type i_chan_a,
    input wire radio_regs_pkg::code2_type i_chan_b,
    // radio core events, one-cycle pulses
    input wire logic i_evt_rx_a,
    input wire logic i_evt_rx_b,
    input wire logic i_evt_wake_fail,
    // synthesizer settings
    output logic [`REG_W-1:0] o_synth_int,
    output logic [3*`REG_W-1:0] o_synth_frac,
    output logic [2*`REG_W-1:0] o_fsk_dev,
    output logic [2*`REG_W-1:0] o_chan_offset,
    // interrupt
    output logic o_irq
);

    import radio_regs_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_n;

    reset_release u_reset_release
    (
        .i_sys_clk(i_sys_clk),
        .i_clk_en(i_clk_en),
        .i_arst_n(i_arst_n),
        .o_rst_n(rst_n)
    );

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic reg_hit
    (
        input logic [`AV_ADDR_W-1:0] addr,
        input logic [`AV_ADDR_W-1:0] idx
    );
        return addr == idx;
    endfunction

    function automatic logic [`AV_ADDR_W-1:0] cfg_idx(input int slot);
        return `AV_ADDR_W'(`IDX_CFG_BASE + slot);
    endfunction

    // ************************************************************
    // bus handshake
    // ************************************************************
    bus_state_type state_ff;
    bus_state_type nxt_state;
    logic wait_ff;
    logic nxt_wait;
    logic [`AV_DATA_W-1:0] rdata_ff;
    logic [`AV_DATA_W-1:0] nxt_rdata;
    logic [`REG_W-1:0] read_byte;
    logic wr_commit;

    // a write only lands at the edge where waitrequest is seen low
    assign wr_commit = (state_ff == BUS_ACK) && i_avs_write
        && i_avs_byteenable[0];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_rdata = rdata_ff;
        case (state_ff)
            BUS_IDLE:
            begin
                if (i_avs_read || i_avs_write)
                begin
                    nxt_state = BUS_ACK;
                    nxt_wait = 1'b0;
                    if (i_avs_read)
                    begin
                        nxt_rdata = {{(`AV_DATA_W-`REG_W){1'b0}}, read_byte};
                    end
                end
            end
            BUS_ACK:
            begin
                nxt_state = BUS_IDLE;
                nxt_wait = 1'b1;
            end
            default:
            begin
                nxt_state = BUS_IDLE;
                nxt_wait = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= '0;
        end
        else if (i_clk_en)
        begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_avs_waitrequest = wait_ff;
    assign o_avs_readdata = rdata_ff;

    // ************************************************************
    // synthesizer configuration bytes
    // ************************************************************
    logic [`REG_W-1:0] cfg_ff [`CFG_COUNT];
    logic [`REG_W-1:0] nxt_cfg [`CFG_COUNT];

    // range checks on the divider are the host's job; bytes are stored as is
    genvar g;
    generate
        for (g = 0; g < `CFG_COUNT; g++)
        begin : g_cfg
            always_comb
            begin
                nxt_cfg[g] = cfg_ff[g];
                if (wr_commit && reg_hit(i_avs_address, cfg_idx(g)))
                begin
                    nxt_cfg[g] = i_avs_writedata[`REG_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `CFG_COUNT; i++)
            begin
                cfg_ff[i] <= `CFG_RESET;
            end
        end
        else if (i_clk_en)
        begin
            for (int i = 0; i < `CFG_COUNT; i++)
            begin
                cfg_ff[i] <= nxt_cfg[i];
            end
        end
    end

    // ************************************************************
    // applied synthesizer words
    // ************************************************************
    // multi-byte words move only when their low byte is written, so the
    // synthesizer never sees a half-updated fraction or offset
    logic [`REG_W-1:0] int_ff;
    logic [3*`REG_W-1:0] frac_ff;
    logic [2*`REG_W-1:0] dev_ff;
    logic [2*`REG_W-1:0] ofs_ff;
    logic [`REG_W-1:0] nxt_int;
    logic [3*`REG_W-1:0] nxt_frac;
    logic [2*`REG_W-1:0] nxt_dev;
    logic [2*`REG_W-1:0] nxt_ofs;

    always_comb
    begin
        nxt_int = nxt_cfg[`SLOT_INT_DIV];
        nxt_frac = frac_ff;
        nxt_dev = dev_ff;
        nxt_ofs = ofs_ff;
        if (wr_commit && reg_hit(i_avs_address, `IDX_FRAC_LOW))
        begin
            nxt_frac = {cfg_ff[`SLOT_FRAC_HIGH], cfg_ff[`SLOT_FRAC_MID],
                nxt_cfg[`SLOT_FRAC_LOW]};
        end
        if (wr_commit && reg_hit(i_avs_address, `IDX_DEV_LOW))
        begin
            nxt_dev = {cfg_ff[`SLOT_DEV_HIGH],
                nxt_cfg[`SLOT_DEV_LOW]};
        end
        if (wr_commit && reg_hit(i_avs_address, `IDX_OFS_LOW))
        begin
            nxt_ofs = {cfg_ff[`SLOT_OFS_HIGH],
                nxt_cfg[`SLOT_OFS_LOW]};
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_ff <= `CFG_RESET;
            frac_ff <= '0;
            dev_ff <= '0;
            ofs_ff <= '0;
        end
        else if (i_clk_en)
        begin
            int_ff <= nxt_int;
            frac_ff <= nxt_frac;
            dev_ff <= nxt_dev;
            ofs_ff <= nxt_ofs;
        end
    end

    assign o_synth_int = int_ff;
    assign o_synth_frac = frac_ff;
    assign o_fsk_dev = dev_ff;
    assign o_chan_offset = ofs_ff;

    // ************************************************************
    // events and interrupt
    // ************************************************************
    logic [`EVT_COUNT-1:0] evt_in;
    logic [`EVT_COUNT-1:0] evt_clear;
    logic [`EVT_COUNT-1:0] evt_status;
    logic [`EVT_COUNT-1:0] evt_mask;
    logic mask_wr;
    code2_type cause;

    always_comb
    begin
        evt_in = '0;
        evt_in[`EVT_RX_A] = i_evt_rx_a;
        evt_in[`EVT_RX_B] = i_evt_rx_b;
        evt_in[`EVT_WAKE_FAIL] = i_evt_wake_fail;
        evt_clear = '0;
        if (wr_commit && reg_hit(i_avs_address, `IDX_IRQ_STATUS))
        begin
            evt_clear = i_avs_writedata[`EVT_COUNT-1:0];
        end
        mask_wr = wr_commit && reg_hit(i_avs_address, `IDX_IRQ_MASK);
    end

    irq_events u_irq_events
    (
        .i_sys_clk(i_sys_clk),
        .i_clk_en(i_clk_en),
        .i_rst_n(rst_n),
        .i_event(evt_in),
        .i_clear(evt_clear),
        .i_mask_wr(mask_wr),
        .i_mask_data(i_avs_writedata[`EVT_COUNT-1:0]),
        .o_status(evt_status),
        .o_mask(evt_mask),
        .o_irq(o_irq)
    );

    // a wake failure outranks pending receive data; the cause drops to
    // the next pending event once the higher one is cleared
    always_comb
    begin
        if (evt_status[`EVT_WAKE_FAIL])
        begin
            cause = `CAUSE_WAKE_FAIL;
        end
        else if (evt_status[`EVT_RX_A])
        begin
            cause = `CAUSE_RX_A;
        end
        else if (evt_status[`EVT_RX_B])
        begin
            cause = `CAUSE_RX_B;
        end
        else
        begin
            cause = `CAUSE_NONE;
        end
    end

    // ************************************************************
    // read multiplexer
    // ************************************************************
    always_comb
    begin
        read_byte = '0;
        case (i_avs_address)
            `IDX_EVT_CLK_WAKE:
            begin
                read_byte = {cause, 2'h0, i_clk_source,
                    i_wake_progress};
            end
            `IDX_CUR_CHANNEL:
            begin
                read_byte = {4'h0, i_chan_a, i_chan_b};
            end
            `IDX_INT_DIV:
            begin
                read_byte = cfg_ff[`SLOT_INT_DIV];
            end
            `IDX_FRAC_HIGH:
            begin
                read_byte = cfg_ff[`SLOT_FRAC_HIGH];
            end
            `IDX_FRAC_MID:
            begin
                read_byte = cfg_ff[`SLOT_FRAC_MID];
            end
            `IDX_FRAC_LOW:
            begin
                read_byte = cfg_ff[`SLOT_FRAC_LOW];
            end
            `IDX_DEV_HIGH:
            begin
                read_byte = cfg_ff[`SLOT_DEV_HIGH];
            end
            `IDX_DEV_LOW:
            begin
                read_byte = cfg_ff[`SLOT_DEV_LOW];
            end
            `IDX_OFS_HIGH:
            begin
                read_byte = cfg_ff[`SLOT_OFS_HIGH];
            end
            `IDX_OFS_LOW:
            begin
                read_byte = cfg_ff[`SLOT_OFS_LOW];
            end
            `IDX_IRQ_STATUS:
            begin
                read_byte = {{(`REG_W-`EVT_COUNT){1'b0}}, evt_status};
            end
            `IDX_IRQ_MASK:
            begin
                read_byte = {{(`REG_W-`EVT_COUNT){1'b0}}, evt_mask};
            end
            default:
            begin
                read_byte = '0;
            end
        endcase
    end

endmodule

// [reset_release.sv]
`timescale 1ns/100ps
module reset_release
(
    // clock
    input wire logic i_sys_clk,
    input wire logic i_clk_en,
    // reset
    input wire logic i_arst_n,
    output logic o_rst_n
);

    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb
    begin
        nxt_meta = 1'b1;
        nxt_sync = meta_ff;
    end

    // assertion is immediate, release takes two enabled edges
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_rst_n = sync_ff;

endmodule

// [tb_radio_status_and_synth_regs.sv]
`timescale 1ns/100ps
`include "radio_regs_params.svh"
module tb_radio_status_and_synth_regs;
    import radio_regs_pkg::*;
    logic clk;
    logic arst_n;
    logic en;
    logic [5:0] addr;
    logic rd;
    logic wr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] want;
    logic waitreq;
    code2_type cs, wp, ca, cb;
    logic [2:0] evt;
    logic [7:0] o_int;
    logic [7:0] div;
    logic [7:0] seed;
    logic [23:0] frac;
    logic [23:0] fr;
    logic [15:0] dev;
    logic [15:0] ofs;
    logic [15:0] dv;
    logic irq;
    int n_mismatch;
    int checks_done;

    radio_status_and_synth_regs u_radio_status_and_synth_regs
    (
        .i_sys_clk(clk), .i_clk_en(en), .i_arst_n(arst_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_byteenable(be), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_clk_source(cs), .i_wake_progress(wp),
        .i_chan_a(ca), .i_chan_b(cb),
        .i_evt_rx_a(evt[1]), .i_evt_rx_b(evt[0]), .i_evt_wake_fail(evt[2]),
        .o_synth_int(o_int), .o_synth_frac(frac), .o_fsk_dev(dev),
        .o_chan_offset(ofs), .o_irq(irq)
    );
    host_bus_model u_host_bus_model
    (
        .i_sys_clk(clk), .i_waitrequest(waitreq), .o_address(addr),
        .o_read(rd), .o_write(wr), .o_byteenable(be), .o_writedata(wdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] st(input logic [1:0] cause);
        return {24'h0, cause, 2'b00, cs, wp};
    endfunction
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        u_host_bus_model.wr(a, {~24'h0, d}, 4'hf);
    endtask
    task automatic get(input logic [5:0] a, input logic [31:0] e);
        u_host_bus_model.rd(a, e);
    endtask
    // high byte first, low byte last commits the word
    task automatic load(input logic [5:0] a, input int n,
        input logic [23:0] v);
        for (int j = n - 1; j >= 0; j--)
            put(a + 6'(n - 1 - j), v[8*j +: 8]);
        for (int j = n - 1; j >= 0; j--)
            get(a + 6'(n - 1 - j), 32'(v[8*j +: 8]));
    endtask
    // leaves the following edge free so a read can be taken right after
    task automatic pulse(input logic [2:0] v);
        evt <= v;
        @(posedge clk);
        evt <= 3'h0;
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'(v));
    endtask

    always @(posedge clk)
    begin
        if (rd && waitreq === 1'b0)
        begin
            want = u_host_bus_model.exp_q.pop_front();
            check(rdata, want);
        end
    end

    initial
    begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        close_out;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        arst_n = 1'b0;
        en = 1'b1;
        cs = 2'h0;
        wp = 2'h0;
        ca = 2'h0;
        cb = 2'h0;
        evt = 3'h0;
        seed = 8'h4e;
        n_mismatch = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 4; i < 12; i++)
            get(6'(i), 32'h0);
        put(6'h0c, 8'hff);
        get(6'h0c, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            cs <= 2'(i);
            wp <= 2'(3 - i);
            ca <= 2'(i);
            cb <= seed[1:0];
            @(posedge clk);
            put(6'h02, seed);
            get(6'h02, st(`CAUSE_NONE));
            put(6'h03, ~seed);
            get(6'h03, {28'h0, ca, cb});
        end
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            div = 8'h1a + 8'(seed % 8'd50);
            put(6'h04, div);
            check(32'(o_int), 32'(div));
            fr = (k == 0) ? 24'h01999b : {seed, ~seed, seed ^ 8'h5a};
            load(6'h05, 3, fr);
            check(32'(frac), 32'(fr));
            dv = (k == 0) ? 16'h0106 : {~seed, seed};
            load(6'h08, 2, 24'(dv));
            check(32'(dev), 32'(dv));
            load(6'h0a, 2, {8'h0, seed, ~seed});
            check(32'(ofs), {16'h0, seed, ~seed});
        end
        u_host_bus_model.wr(6'h04, 32'h33, 4'he);
        check(32'(o_int), 32'(div));
        pulse(3'h1);
        get(6'h02, st(`CAUSE_RX_B));
        get(6'h10, 32'h1);
        irq_is(1'b0);
        put(6'h11, 8'h07);
        irq_is(1'b1);
        pulse(3'h2);
        get(6'h02, st(`CAUSE_RX_A));
        put(6'h11, 8'h00);
        irq_is(1'b0);
        put(6'h11, 8'h07);
        wp <= 2'h3;
        pulse(3'h4);
        get(6'h02, st(`CAUSE_WAKE_FAIL));
        wp <= 2'h2;
        @(posedge clk);
        put(6'h10, 8'h04);
        get(6'h02, st(`CAUSE_RX_A));
        put(6'h10, 8'h03);
        get(6'h02, st(`CAUSE_NONE));
        irq_is(1'b0);
        // with the enable low the whole block is frozen, so the event
        // must leave neither a status bit nor an interrupt behind
        en <= 1'b0;
        pulse(3'h4);
        irq_is(1'b0);
        en <= 1'b1;
        @(posedge clk);
        get(6'h02, st(`CAUSE_NONE));
        repeat (2) @(posedge clk);
        close_out;
    end
endmodule
